// file: hw/tdp_pkg.sv
// constants, types and timing for the two-wire potentiometer slave
package tdp_pkg;

    // device type code: value is arbitrary
    localparam logic [3:0] DEV_TYPE_ID   = 4'hA;
    localparam int         ADDR_TYPE_LSB = 4;
    localparam int         ADDR_BIT_LOW  = 0;
    localparam int         ADDR_BIT_MID  = 2;
    localparam int         ADDR_BIT_HIGH = 3;
    localparam int         CMD_INSTR_LSB = 4;
    localparam int         CMD_SEL_LSB   = 2;

    localparam logic [3:0] INS_RD_WIPER = 4'h9;
    localparam logic [3:0] INS_WR_WIPER = 4'hA;
    localparam logic [3:0] INS_RD_DR   = 4'hB;
    localparam logic [3:0] INS_WR_DR   = 4'hC;
    localparam logic [3:0] INS_XFR_D2W = 4'hD;
    localparam logic [3:0] INS_XFR_W2D = 4'hE;
    localparam logic [3:0] INS_INCDEC  = 4'h2;

    localparam logic [5:0] WIPER_MAX   = 6'h3F;
    localparam logic [5:0] WIPER_MIN   = 6'h00;
    localparam logic [5:0] PRESET_RST  = 6'h00;
    localparam logic [3:0] BITS_BYTE   = 4'h8;

    localparam int CLK_FREQ_KHZ  = 125000;
    localparam int NV_WRITE_US   = 5000;
    localparam int NV_MAX_US     = 10000;
    localparam int NV_WRITE_CYC  = NV_WRITE_US * (CLK_FREQ_KHZ / 1000);
    localparam int NV_MAX_CYC    = NV_MAX_US * (CLK_FREQ_KHZ / 1000);
    localparam int FIFO_DEPTH    = 32;

    typedef enum logic [1:0] {
        K_CMD  = 2'h0,
        K_DATA = 2'h1,
        K_STOP = 2'h2,
        K_STEP = 2'h3
    } tdp_kind_t;

    typedef struct packed {
        tdp_kind_t  kind;
        logic [7:0] data;
    } tdp_entry_t;

    typedef enum logic [5:0] {
        S_IDLE = 6'h01,
        S_RECV = 6'h02,
        S_ACK  = 6'h04,
        S_SEND = 6'h08,
        S_STEP = 6'h10,
        S_WAIT = 6'h20
    } tdp_state_t;

endpackage : tdp_pkg

// file: hw/tdp_fifo.sv
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module tdp_fifo #(
    parameter int W = 10,
    parameter int D = 32
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    input  wire logic [W-1:0] in_data_i,
    output logic              out_valid_o,
    input  wire logic         out_ready_i,
    output logic [W-1:0]      out_data_o
);
    localparam int AW = $clog2(D);

    logic [W-1:0] mem_reg [D];
    logic [AW:0]  wr_ptr_reg;
    logic [AW:0]  rd_ptr_reg;

    wire empty = (wr_ptr_reg == rd_ptr_reg);
    wire full  = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) && (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
    wire push  = in_valid_i && !full;
    wire pop   = out_ready_i && !empty;
    wire [AW:0] rd_ptr_next = rd_ptr_reg + (AW+1)'(pop);
    // read word is registered; a push into the slot read next bypasses the memory
    wire bypass = push && (wr_ptr_reg[AW-1:0] == rd_ptr_next[AW-1:0]);
    logic [W-1:0] out_data_reg;

    assign in_ready_o  = !full;
    assign out_valid_o = !empty;
    assign out_data_o  = out_data_reg;

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_reg[wr_ptr_reg[AW-1:0]] <= in_data_i;
        end
        out_data_reg <= bypass ? in_data_i : mem_reg[rd_ptr_next[AW-1:0]];
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            wr_ptr_reg <= wr_ptr_reg + (AW+1)'(push);
            rd_ptr_reg <= rd_ptr_reg + (AW+1)'(pop);
        end
    end

endmodule : tdp_fifo
`default_nettype wire

// file: hw/tdp_pot_slave.sv
// two-wire slave front end and wiper/preset register logic of a digital potentiometer
// What this block does
// - data line is open drain: only pulled low or released.
// - data changes only while clock low; changes while high are start/stop.
// - watch for start always; ignore everything until one is seen.
// - after eight bits transmitter releases; receiver pulls low on ninth clock.
// - acknowledge address, command, and a following data byte.
// - upper four address bits must equal the fixed type code.
// - three strap inputs give low address bits.
// - acknowledge address only when all three strap bits match.
// - write-protect low blocks every nonvolatile preset write.
// - six-bit wiper decodes to sixty-four tap enables end to end.
// - tap enables are one-hot.
// - wiper loadable by host write or from any of four presets.
// - nonvolatile write starts at the stop that ends its command.
// - withhold address acknowledge while nonvolatile write busy.
// - nonvolatile busy period about five milliseconds; inputs ignored meanwhile.
// - command: instruction high nibble, two-bit select, two zero bits.
// - after inc/dec command each clock steps wiper by data level.
// - after power-up wiper takes preset register zero.
// - preset-changing operations finish within ten milliseconds.
`timescale 1ns/1ps
`default_nettype none
module tdp_pot_slave
    import tdp_pkg::*;
#(
    parameter int NV_CYCLES = NV_WRITE_CYC
) (
    input  wire logic        MCLK_I,
    input  wire logic        RST_I,
    input  wire logic        SCL_I,
    input  wire logic        SDA_I,
    output logic             SDA_O,
    output logic             SDA_OE_O,
    input  wire logic        ADDR_STRAP_BIT_LOW_I,
    input  wire logic        ADDR_STRAP_BIT_MID_I,
    input  wire logic        ADDR_STRAP_BIT_HIGH_I,
    input  wire logic        WRITE_PROTECT_N_I,
    output logic [63:0]      TAP_EN_O,
    output logic [5:0]       WIPER_O,
    output logic             NV_BUSY_O
);
    // ---- pin synchronisers: stage 1 feeds stage 2 only
    logic [5:0] sync1_reg;
    logic [5:0] sync2_reg;
    logic       scl_prev_reg;
    logic       sda_prev_reg;

    always_ff @(posedge MCLK_I) begin
        sync1_reg <= {WRITE_PROTECT_N_I, ADDR_STRAP_BIT_HIGH_I, ADDR_STRAP_BIT_MID_I,
                      ADDR_STRAP_BIT_LOW_I, SDA_I, SCL_I};
        sync2_reg <= sync1_reg;
        scl_prev_reg <= sync2_reg[0];
        sda_prev_reg <= sync2_reg[1];
    end

    wire scl_s    = sync2_reg[0];
    wire sda_s    = sync2_reg[1];
    wire wp_n_s   = sync2_reg[5];
    wire scl_rise = scl_s && !scl_prev_reg;
    wire scl_fall = !scl_s && scl_prev_reg;
    // edges of data while clock stays high are framing only
    wire start_ev = scl_s && scl_prev_reg && sda_prev_reg && !sda_s;
    wire stop_ev  = scl_s && scl_prev_reg && !sda_prev_reg && sda_s;

    // ---- serial side state
    tdp_state_t state_reg;
    tdp_state_t state_next;
    logic [7:0] shift_reg;
    logic [3:0] bit_cnt_reg;
    logic [1:0] byte_idx_reg;
    logic       sda_oe_reg;
    logic       after_ack_send_reg;
    logic       after_ack_step_reg;
    logic       after_ack_recv_reg;
    logic       in_txn_reg;

    logic       nv_busy_reg;
    logic [5:0] wiper_reg;
    logic [5:0] preset_reg [4] = '{default: PRESET_RST};

    logic       fifo_ready;
    logic       fifo_valid;
    tdp_entry_t fifo_out;

    wire byte_done  = (bit_cnt_reg == BITS_BYTE);
    wire [7:0] rx_byte = shift_reg;
    wire [3:0] rx_instr = rx_byte[CMD_INSTR_LSB +: 4];
    wire [1:0] rx_sel   = rx_byte[CMD_SEL_LSB +: 2];
    wire type_ok    = (rx_byte[ADDR_TYPE_LSB +: 4] == DEV_TYPE_ID);
    wire strap_ok   = (rx_byte[ADDR_BIT_LOW]  == sync2_reg[2])
                   && (rx_byte[ADDR_BIT_MID]  == sync2_reg[3])
                   && (rx_byte[ADDR_BIT_HIGH] == sync2_reg[4]);
    // address is refused while the preset write runs
    wire addr_ack   = type_ok && strap_ok && !nv_busy_reg && fifo_ready;
    wire is_read    = (rx_instr == INS_RD_WIPER) || (rx_instr == INS_RD_DR);
    wire is_step    = (rx_instr == INS_INCDEC);
    wire is_3byte   = (rx_instr == INS_WR_WIPER) || (rx_instr == INS_WR_DR);
    wire cmd_known  = is_read || is_step || is_3byte
                   || (rx_instr == INS_XFR_D2W) || (rx_instr == INS_XFR_W2D);
    wire cmd_ack    = cmd_known && (rx_byte[1:0] == 2'b00) && fifo_ready;
    wire data_ack   = fifo_ready;
    wire this_ack   = (byte_idx_reg == 2'd0) ? addr_ack :
                      (byte_idx_reg == 2'd1) ? cmd_ack : data_ack;
    wire byte_end   = (state_reg == S_RECV) && scl_fall && byte_done;
    wire [5:0] rd_val = (rx_instr == INS_RD_WIPER) ? wiper_reg : preset_reg[rx_sel];

    // fifo push: command and data bytes as they are acknowledged, steps, stops
    wire push_byte  = byte_end && this_ack && (byte_idx_reg != 2'd0);
    // a step counts when its clock pulse ends, so the pulse closed by a stop never steps
    wire push_step  = (state_reg == S_STEP) && scl_fall;
    wire push_stop  = stop_ev && in_txn_reg;
    tdp_entry_t push_ent;
    assign push_ent.kind = push_stop ? K_STOP : push_step ? K_STEP :
                           (byte_idx_reg == 2'd1) ? K_CMD : K_DATA;
    assign push_ent.data = push_step ? {7'h00, sda_s} : rx_byte;
    wire push_any   = push_byte || push_step || push_stop;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            S_IDLE: state_next = S_IDLE;
            S_RECV: if (byte_end) begin
                state_next = this_ack ? S_ACK : S_IDLE;
            end
            S_ACK: if (scl_fall) begin
                state_next = after_ack_send_reg ? S_SEND :
                             after_ack_step_reg ? S_STEP :
                             after_ack_recv_reg ? S_RECV : S_WAIT;
            end
            S_SEND: if (scl_fall && byte_done) begin
                state_next = S_WAIT;
            end
            S_STEP: state_next = S_STEP;
            S_WAIT: state_next = S_WAIT;
            default: state_next = S_IDLE;
        endcase
        if (start_ev) begin
            state_next = S_RECV;
        end else if (stop_ev) begin
            state_next = S_IDLE;
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
            state_reg <= S_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (RST_I || start_ev || (state_reg == S_ACK && scl_fall)) begin
            bit_cnt_reg <= 4'h0;
        end else if ((state_reg == S_RECV || state_reg == S_SEND) && scl_rise) begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
            shift_reg <= 8'h00;
        end else if (state_reg == S_RECV && scl_rise) begin
            shift_reg <= {shift_reg[6:0], sda_s};
        end else if (byte_end && byte_idx_reg == 2'd1 && is_read) begin
            shift_reg <= {2'b00, rd_val};
        end else if (state_reg == S_SEND && scl_fall) begin
            shift_reg <= {shift_reg[6:0], 1'b0};
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (RST_I || start_ev) begin
            byte_idx_reg       <= 2'd0;
            after_ack_send_reg <= 1'b0;
            after_ack_step_reg <= 1'b0;
            after_ack_recv_reg <= 1'b1;
        end else if (byte_end && this_ack) begin
            byte_idx_reg       <= byte_idx_reg + 2'd1;
            after_ack_send_reg <= (byte_idx_reg == 2'd1) && is_read;
            after_ack_step_reg <= (byte_idx_reg == 2'd1) && is_step;
            after_ack_recv_reg <= (byte_idx_reg == 2'd0) || ((byte_idx_reg == 2'd1) && is_3byte);
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (RST_I || start_ev || stop_ev) begin
            in_txn_reg <= 1'b0;
        end else if (push_byte && byte_idx_reg == 2'd1) begin
            in_txn_reg <= 1'b1;
        end
    end

    // line is only ever pulled low, changed just after clock falls and released at start or stop
    always_ff @(posedge MCLK_I) begin
        if (RST_I || start_ev || stop_ev) begin
            sda_oe_reg <= 1'b0;
        end else if (byte_end) begin
            sda_oe_reg <= this_ack;
        end else if (state_reg == S_ACK && scl_fall) begin
            sda_oe_reg <= after_ack_send_reg && !shift_reg[7];
        end else if (state_reg == S_SEND && scl_fall) begin
            sda_oe_reg <= !byte_done && !shift_reg[6];
        end
    end

    assign SDA_O    = 1'b0;
    assign SDA_OE_O = sda_oe_reg;

    // ---- byte queue between serial side and register side
    logic pop;
    tdp_fifo #(.W($bits(tdp_entry_t)), .D(FIFO_DEPTH)) u_fifo (
        .clk_i       (MCLK_I),
        .rst_i       (RST_I),
        .in_valid_i  (push_any),
        .in_ready_o  (fifo_ready),
        .in_data_i   (push_ent),
        .out_valid_o (fifo_valid),
        .out_ready_i (pop),
        .out_data_o  (fifo_out)
    );

    // ---- register side; the queue stalls while a preset write runs
    assign pop = fifo_valid && !nv_busy_reg;
    logic [3:0]  ex_instr_reg;
    logic        nv_pend_reg;
    logic [5:0]  nv_data_reg;
    logic [1:0]  nv_sel_reg;
    logic [19:0] nv_cnt_reg;
    logic        recall_reg;

    wire pop_cmd  = pop && fifo_out.kind == K_CMD;
    wire pop_data = pop && fifo_out.kind == K_DATA;
    wire pop_stop = pop && fifo_out.kind == K_STOP;
    wire pop_step = pop && fifo_out.kind == K_STEP;
    wire [3:0] p_ins = fifo_out.data[CMD_INSTR_LSB +: 4];
    wire [1:0] p_sel = fifo_out.data[CMD_SEL_LSB +: 2];
    wire nv_start = pop_stop && nv_pend_reg && wp_n_s;
    wire nv_done  = nv_busy_reg && (nv_cnt_reg == 20'(NV_CYCLES - 1));
    wire step_up  = fifo_out.data[0];

    always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
            recall_reg <= 1'b1;
        end else begin
            recall_reg <= 1'b0;
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
            ex_instr_reg <= 4'h0;
            nv_pend_reg  <= 1'b0;
            nv_data_reg  <= PRESET_RST;
            nv_sel_reg   <= 2'd0;
        end else if (pop_cmd) begin
            ex_instr_reg <= p_ins;
            nv_pend_reg  <= (p_ins == INS_XFR_W2D);
            nv_data_reg  <= wiper_reg;
            nv_sel_reg   <= p_sel;
        end else if (pop_data && ex_instr_reg == INS_WR_DR) begin
            nv_pend_reg  <= 1'b1;
            nv_data_reg  <= fifo_out.data[5:0];
        end else if (pop_stop) begin
            nv_pend_reg  <= 1'b0;
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
            wiper_reg <= WIPER_MIN;
        end else if (recall_reg) begin
            wiper_reg <= preset_reg[0];
        end else if (pop_cmd && p_ins == INS_XFR_D2W) begin
            wiper_reg <= preset_reg[p_sel];
        end else if (pop_data && ex_instr_reg == INS_WR_WIPER) begin
            wiper_reg <= fifo_out.data[5:0];
        end else if (pop_step && step_up && wiper_reg != WIPER_MAX) begin
            wiper_reg <= wiper_reg + 6'h01;
        end else if (pop_step && !step_up && wiper_reg != WIPER_MIN) begin
            wiper_reg <= wiper_reg - 6'h01;
        end
    end

    // presets survive the logic reset, standing in for nonvolatile cells
    always_ff @(posedge MCLK_I) begin
        if (nv_done) begin
            preset_reg[nv_sel_reg] <= nv_data_reg;
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (RST_I || nv_done) begin
            nv_busy_reg <= 1'b0;
            nv_cnt_reg  <= 20'h00000;
        end else if (nv_start) begin
            nv_busy_reg <= 1'b1;
            nv_cnt_reg  <= 20'h00000;
        end else if (nv_busy_reg) begin
            nv_cnt_reg  <= nv_cnt_reg + 20'h00001;
        end
    end

    // ---- tap decode
    logic [63:0] tap_reg;
    genvar gi;
    generate
        for (gi = 0; gi < 64; gi++) begin : g_tap
            always_ff @(posedge MCLK_I) begin
                if (RST_I) begin
                    tap_reg[gi] <= (gi == 0);
                end else begin
                    tap_reg[gi] <= (wiper_reg == 6'(gi));
                end
            end
        end
    endgenerate

    assign TAP_EN_O  = tap_reg;
    assign WIPER_O   = wiper_reg;
    assign NV_BUSY_O = nv_busy_reg;

    // ---- checks
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (RST_I);

    chk_tap_onehot: assert property ($onehot(TAP_EN_O))
        else $error("tap enables not one-hot");
    chk_tap_decode: assert property (##1 TAP_EN_O == (64'h1 << $past(wiper_reg)))
        else $error("tap enable does not follow wiper");
    chk_oe_clk_low: assert property ($rose(sda_oe_reg) |-> !scl_s)
        else $error("data line pulled while clock high");
    chk_busy_no_ack: assert property (byte_end && byte_idx_reg == 2'd0 && nv_busy_reg |=> !sda_oe_reg)
        else $error("address acknowledged while busy");
    chk_addr_match: assert property (byte_end && byte_idx_reg == 2'd0 && !(type_ok && strap_ok)
                                     |=> state_reg == S_IDLE && !sda_oe_reg)
        else $error("mismatched address not ignored");
    chk_wp_block: assert property (pop_stop && !wp_n_s |=> !nv_busy_reg)
        else $error("preset write started while protected");
    chk_nv_on_stop: assert property ($rose(nv_busy_reg) |-> $past(pop_stop))
        else $error("preset write started without stop");
    chk_nv_length: assert property ({12'h000, nv_cnt_reg} < NV_MAX_CYC)
        else $error("preset write too long");
    chk_step_sat: assert property (pop_step && !step_up && wiper_reg == WIPER_MIN
                                   |=> wiper_reg == WIPER_MIN)
        else $error("wiper wrapped below lowest tap");
    chk_step_up: assert property (pop_step && step_up && wiper_reg != WIPER_MAX
                                  |=> wiper_reg == $past(wiper_reg) + 6'h01)
        else $error("wiper did not step up");
    chk_recall: assert property (recall_reg |=> wiper_reg == $past(preset_reg[0]))
        else $error("wiper not recalled from preset zero");

    cov_addr_ack: cover property (byte_end && byte_idx_reg == 2'd0 && addr_ack);
    cov_nv_write: cover property (nv_done);
    cov_step:     cover property (pop_step);

endmodule : tdp_pot_slave
`default_nettype wire

// file: dv/tdp_bus_master.sv
// two-wire bus master model: makes the serial clock and drives data open drain
`timescale 1ns/1ps
`default_nettype none
module tdp_bus_master (
    input  wire logic clk_i,
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_low_o
);
    // clock stands high and data is released between frames
    initial begin
        scl_o     = 1'b1;
        sda_low_o = 1'b0;
    end
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk_i);
    endtask : wait_clk
    // one 80 ns bit; data moves only in the low phase
    task automatic put_bit(input logic b, output logic seen);
        wait_clk(2);
        sda_low_o <= ~b;
        wait_clk(3);
        scl_o <= 1'b1;
        wait_clk(5);
        seen = sda_i;
        scl_o <= 1'b0;
    endtask : put_bit
    // data edge while the clock is high: start falls, stop rises
    task automatic cond(input logic is_start);
        wait_clk(2);
        sda_low_o <= ~is_start;
        wait_clk(3);
        scl_o <= 1'b1;
        wait_clk(5);
        sda_low_o <= is_start;
        wait_clk(5);
        scl_o <= ~is_start;
    endtask : cond
    // msb first, then a ninth clock with the given level; 1 releases the line
    task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] got, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            put_bit(d[i], s);
            got[i] = s;
        end
        put_bit(last, s);
        ack = ~s;
    endtask : xfer
endmodule : tdp_bus_master
`default_nettype wire

// file: dv/test_tdp_pot_slave.sv
// self-checking bench of the two-wire potentiometer slave
`timescale 1ns/1ps
`default_nettype none
module test_tdp_pot_slave;
    import tdp_pkg::*;
    localparam int         NV_SIM = 200;
    localparam logic [7:0] ADDR   = {DEV_TYPE_ID, 4'hD};
    logic        mclk;
    logic        rst;
    logic        scl;
    logic        sda_low;
    logic        sda_out;
    logic        sda_oe;
    logic [2:0]  strap;
    logic        wp_n;
    logic [63:0] tap_en;
    logic [5:0]  wiper;
    logic        nv_busy;
    int          err_count;
    int          samples_checked;
    // pull-up: high unless a party pulls low
    wire logic   sda = ~(sda_low | sda_oe);
    tdp_pot_slave #(.NV_CYCLES(NV_SIM)) i_tdp_pot_slave (.MCLK_I(mclk), .RST_I(rst), .SCL_I(scl), .SDA_I(sda),
        .SDA_O(sda_out), .SDA_OE_O(sda_oe), .ADDR_STRAP_BIT_LOW_I(strap[0]), .ADDR_STRAP_BIT_MID_I(strap[1]),
        .ADDR_STRAP_BIT_HIGH_I(strap[2]), .WRITE_PROTECT_N_I(wp_n), .TAP_EN_O(tap_en), .WIPER_O(wiper),
        .NV_BUSY_O(nv_busy));
    tdp_bus_master i_tdp_bus_master (.clk_i(mclk), .sda_i(sda), .scl_o(scl), .sda_low_o(sda_low));
    always #4 mclk = ~mclk;
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_of_test
    task automatic chk_val(input string what, input logic [63:0] exp, input logic [63:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_val
    task automatic chk_ack(input string what, input logic exp, input logic got);
        chk_val(what, {63'h0, exp}, {63'h0, got});
    endtask : chk_ack
    task automatic chk_pos(input logic [5:0] exp);
        chk_val("wiper", {58'h0, exp}, {58'h0, wiper});
        chk_val("tap enables", 64'h1 << exp, tap_en);
    endtask : chk_pos
    task automatic cmd(input logic [7:0] adr, input logic [7:0] c, output logic a1, output logic a2);
        logic [7:0] g;
        i_tdp_bus_master.cond(1'b1);
        i_tdp_bus_master.xfer(adr, 1'b1, g, a1);
        i_tdp_bus_master.xfer(c, 1'b1, g, a2);
    endtask : cmd
    task automatic write3(input logic [7:0] c, input logic [7:0] d);
        logic a1;
        logic a2;
        logic a3;
        logic [7:0] g;
        cmd(ADDR, c, a1, a2);
        i_tdp_bus_master.xfer(d, 1'b1, g, a3);
        i_tdp_bus_master.cond(1'b0);
        chk_ack("write acks", 1'b1, a1 & a2 & a3);
    endtask : write3
    task automatic read3(input logic [7:0] c, output logic [7:0] v);
        logic a1;
        logic a2;
        logic a3;
        cmd(ADDR, c, a1, a2);
        i_tdp_bus_master.xfer(8'hFF, 1'b1, v, a3);
        i_tdp_bus_master.cond(1'b0);
        chk_ack("read acks", 1'b1, a1 & a2);
    endtask : read3
    task automatic two_byte(input logic [7:0] c);
        logic a1;
        logic a2;
        cmd(ADDR, c, a1, a2);
        i_tdp_bus_master.cond(1'b0);
        chk_ack("two byte acks", 1'b1, a1 & a2);
    endtask : two_byte
    task automatic wait_idle();
        int n;
        n = 0;
        while (nv_busy !== 1'b0 && n < NV_SIM + 100) begin
            @(posedge mclk);
            n++;
        end
        chk_val("write cycle end", 64'h0, {63'h0, nv_busy});
    endtask : wait_idle
    task automatic t_reset(input logic [5:0] exp);
        @(posedge mclk);
        rst <= 1'b1;
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        repeat (5) @(posedge mclk);
        chk_pos(exp);
        $display("reset test done");
    endtask : t_reset
    task automatic t_wiper();
        logic [7:0] v;
        write3({INS_WR_WIPER, 4'h0}, 8'h3E);
        chk_pos(6'h3E);
        read3({INS_RD_WIPER, 4'h0}, v);
        chk_val("wiper read", 64'h3E, {56'h0, v});
        chk_val("data output level", 64'h0, {63'h0, sda_out});
        $display("wiper test done");
    endtask : t_wiper
    task automatic t_steps();
        logic a1;
        logic a2;
        logic s;
        write3({INS_WR_WIPER, 4'h0}, 8'h01);
        cmd(ADDR, {INS_INCDEC, 4'h0}, a1, a2);
        for (int i = 0; i < 5; i++)
            i_tdp_bus_master.put_bit(i > 2, s);
        i_tdp_bus_master.cond(1'b0);
        chk_pos(6'h02);
        cmd(ADDR, {INS_INCDEC, 4'h0}, a1, a2);
        for (int i = 0; i < 70; i++)
            i_tdp_bus_master.put_bit(1'b1, s);
        i_tdp_bus_master.cond(1'b0);
        chk_pos(6'h3F);
        $display("step test done");
    endtask : t_steps
    task automatic t_match();
        logic a1;
        logic a2;
        logic [7:0] bad [5] = '{ADDR ^ 8'h80, ADDR ^ 8'h10, ADDR ^ 8'h08, ADDR ^ 8'h04, ADDR ^ 8'h01};
        foreach (bad[i]) begin
            cmd(bad[i], {INS_WR_WIPER, 4'h0}, a1, a2);
            i_tdp_bus_master.cond(1'b0);
            chk_ack("foreign address ack", 1'b0, a1 | a2);
        end
        cmd(ADDR, 8'hA1, a1, a2);
        i_tdp_bus_master.cond(1'b0);
        chk_ack("bad command ack", 1'b0, a2);
        strap <= 3'b000;
        cmd(ADDR ^ 8'h0D, {INS_INCDEC, 4'h0}, a1, a2);
        i_tdp_bus_master.cond(1'b0);
        chk_ack("strap address ack", 1'b1, a1 & a2);
        strap <= 3'b111;
        chk_pos(6'h3F);
        $display("address test done");
    endtask : t_match
    task automatic t_nv();
        logic a1;
        logic [7:0] v;
        wp_n <= 1'b0;
        write3({INS_WR_DR, 4'h8}, 8'h15);
        repeat (3) @(posedge mclk);
        chk_val("protected busy", 64'h0, {63'h0, nv_busy});
        read3({INS_RD_DR, 4'h8}, v);
        chk_val("protected preset", 64'h0, {56'h0, v});
        wp_n <= 1'b1;
        write3({INS_WR_DR, 4'h8}, 8'h15);
        repeat (3) @(posedge mclk);
        chk_val("write busy", 64'h1, {63'h0, nv_busy});
        i_tdp_bus_master.cond(1'b1);
        i_tdp_bus_master.xfer(ADDR, 1'b1, v, a1);
        chk_ack("poll while busy", 1'b0, a1);
        wait_idle();
        i_tdp_bus_master.cond(1'b1);
        i_tdp_bus_master.xfer(ADDR, 1'b1, v, a1);
        i_tdp_bus_master.cond(1'b0);
        chk_ack("poll when idle", 1'b1, a1);
        read3({INS_RD_DR, 4'h8}, v);
        chk_val("preset read", 64'h15, {56'h0, v});
        two_byte({INS_XFR_D2W, 4'h8});
        chk_pos(6'h15);
        two_byte({INS_XFR_W2D, 4'h0});
        wait_idle();
        t_reset(6'h15);
        $display("preset test done");
    endtask : t_nv
    task automatic t_queue();
        logic a1;
        logic a2;
        logic s;
        // more steps than the queue holds, so its pointers wrap
        cmd(ADDR, {INS_INCDEC, 4'h0}, a1, a2);
        for (int i = 0; i < 45; i++)
            i_tdp_bus_master.put_bit(i > 39, s);
        i_tdp_bus_master.cond(1'b0);
        repeat (3) @(posedge mclk);
        chk_ack("queued step acks", 1'b1, a1 & a2);
        chk_pos(6'h05);
        chk_val("step busy", 64'h0, {63'h0, nv_busy});
        $display("queue test done");
    endtask : t_queue
    initial begin
        mclk = 1'b0;
        rst = 1'b1;
        strap = 3'b111;
        wp_n = 1'b1;
        err_count = 0;
        samples_checked = 0;
        t_reset(6'h00);
        t_wiper();
        t_steps();
        t_match();
        t_nv();
        t_queue();
        end_of_test();
    end
    initial begin
        repeat (100000) @(posedge mclk);
        err_count++;
        $display("watchdog expired");
        end_of_test();
    end
endmodule : test_tdp_pot_slave
`default_nettype wire
